//--- design/jdbs_pkg.sv
// How it works
// - Debug-mode input high connects the JTAG pins to the TAP controller.
// - A 4-bit instruction code chooses which data register sits between TDI and TDO.
// - Code 0000 selects the one-stage bypass path, one test clock of delay.
// - Code 1111 selects the 32-bit identification register for shifting.
// - Registers capture, shift and update only in their TAP controller states.
// - Eight independent breakpoints watch address and data events on the buses.
// - Each breakpoint has setup, match address and comparison data registers.
// - Snooper runs only while enabled; enable clears on break interrupt, logic halts.
// - 16-bit countdown decrements on each match event while above zero; a count write in the same cycle wins.
// - A match event while the countdown holds zero raises the break interrupt.
// - On the break interrupt the instruction address is captured into 16 bits.
// - Setup bit 7 triggered, 6:5 bus, 4:3 access kind, 2:0 condition.
// - Triggered flag sets when its breakpoint causes the break interrupt.
// - Bus code 00 instruction, 01 X, 10 Y; 11 must not be written.
// - Access 00 off, 01 fetch or read, 10 write, 11 read or write.
// - Condition 000 off, 001 address only.
// - Condition 010 data equal, 011 data not equal.
// - Condition 100 signed less, 101 signed greater or equal; 110, 111 unused.
package jdbs_pkg;
   localparam int JDBS_ADDR_W = 16;
   localparam int JDBS_DATA_W = 32;
   localparam int JDBS_NUM_BP = 8;
   localparam int JDBS_IR_W = 4;
   localparam logic [3:0] JDBS_IR_BYPASS = 4'h0;
   localparam logic [3:0] JDBS_IR_IDCODE = 4'hF;
   localparam logic [3:0] JDBS_IR_CAPTURE = 4'h1;
   // Identification value is arbitrary
   localparam logic [31:0] JDBS_IDCODE_DEF = 32'h1234_5671;
   localparam logic [11:0] JDBS_OFS_CTRL = 12'h000;
   localparam logic [11:0] JDBS_OFS_COUNT = 12'h004;
   localparam logic [11:0] JDBS_OFS_BREAK_INSTRUCTION_ADDRESS = 12'h008;
   localparam logic [11:0] JDBS_OFS_BP_BASE = 12'h040;
   localparam logic [1:0] JDBS_SUB_SETUP = 2'h0;
   localparam logic [1:0] JDBS_SUB_ADDR = 2'h1;
   localparam logic [1:0] JDBS_SUB_DATA = 2'h2;
   localparam int JDBS_CTRL_EN_BIT = 0;
   localparam int JDBS_TRIG_BIT = 7;
   localparam int JDBS_BUS_LSB = 5;
   localparam int JDBS_ACC_LSB = 3;
   localparam int JDBS_COND_LSB = 0;
   localparam logic [1:0] JDBS_BUS_I = 2'h0;
   localparam logic [1:0] JDBS_BUS_X = 2'h1;
   localparam logic [1:0] JDBS_BUS_Y = 2'h2;
   localparam logic [1:0] JDBS_ACC_RD = 2'h1;
   localparam logic [1:0] JDBS_ACC_WR = 2'h2;
   localparam logic [1:0] JDBS_ACC_RW = 2'h3;
   localparam logic [2:0] JDBS_COND_ANY = 3'h1;
   localparam logic [2:0] JDBS_COND_EQ = 3'h2;
   localparam logic [2:0] JDBS_COND_NE = 3'h3;
   localparam logic [2:0] JDBS_COND_LT = 3'h4;
   localparam logic [2:0] JDBS_COND_GE = 3'h5;
   localparam logic [7:0] JDBS_SETUP_RST = 8'h00;
   localparam logic [15:0] JDBS_COUNT_RST = 16'h0000;
   localparam int JDBS_TMS_RESET_CNT = 5;

   typedef enum logic [3:0] {
      TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
      TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR,
      TAP_EX2_IR, TAP_UPD_IR
   } jdbs_tap_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [JDBS_ADDR_W-1:0] addr;
      logic [JDBS_DATA_W-1:0] data;
   } jdbs_bus_t;
endpackage : jdbs_pkg

//--- design/jdbs_top.sv
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module jdbs_top import jdbs_pkg::*; #(
   parameter int NUM_BP = JDBS_NUM_BP,
   parameter logic [31:0] IDCODE = JDBS_IDCODE_DEF
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic DBG_MODE,
   input wire logic TCK,
   input wire logic TMS,
   input wire logic TDI,
   output logic TDO,
   output logic TDO_OE,
   output logic BREAK_REQ,
   input wire jdbs_bus_t I_BUS,
   input wire jdbs_bus_t X_BUS,
   input wire jdbs_bus_t Y_BUS,
   input wire logic [JDBS_ADDR_W-1:0] INSTR_ADDR
);
   // Pin synchronisers: stage 1 feeds stage 2 only
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic tck_prev_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         // TCK stages start high, so release makes no false rise; a low idle only reloads TDO
         sync1_q <= 4'h4;
         sync2_q <= 4'h4;
         tck_prev_q <= 1'b1;
      end else begin
         sync1_q <= {DBG_MODE, TCK, TMS, TDI};
         sync2_q <= sync1_q;
         tck_prev_q <= sync2_q[2];
      end
   end
   logic dbg_on;
   logic tms_s;
   logic tdi_s;
   logic tck_rise;
   logic tck_fall;
   assign dbg_on = sync2_q[3];
   assign tms_s = sync2_q[1];
   assign tdi_s = sync2_q[0];
   assign tck_rise = dbg_on && sync2_q[2] && !tck_prev_q;
   assign tck_fall = dbg_on && !sync2_q[2] && tck_prev_q;

   function automatic jdbs_tap_t tap_next(input jdbs_tap_t s, input logic m);
      case (s)
         TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
         TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
         TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_SH_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
         TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PA_DR;
         TAP_PA_DR: tap_next = m ? TAP_EX2_DR : TAP_PA_DR;
         TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
         TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
         TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_SH_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
         TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PA_IR;
         TAP_PA_IR: tap_next = m ? TAP_EX2_IR : TAP_PA_IR;
         TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
         TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
         default: tap_next = TAP_RESET;
      endcase
   endfunction : tap_next

   jdbs_tap_t tap_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tap_q <= TAP_RESET;
      end else if (!dbg_on) begin
         tap_q <= TAP_RESET;
      end else if (tck_rise) begin
         tap_q <= tap_next(tap_q, tms_s);
      end
   end

   // Instruction register; reset selects the identification register
   logic [JDBS_IR_W-1:0] ir_q;
   logic [JDBS_IR_W-1:0] ir_sh_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ir_q <= JDBS_IR_IDCODE;
         ir_sh_q <= JDBS_IR_CAPTURE;
      end else if (tap_q == TAP_RESET) begin
         ir_q <= JDBS_IR_IDCODE;
      end else if (tap_q == TAP_UPD_IR) begin
         ir_q <= ir_sh_q;
      end else if (tck_rise && tap_q == TAP_CAP_IR) begin
         ir_sh_q <= JDBS_IR_CAPTURE;
      end else if (tck_rise && tap_q == TAP_SH_IR) begin
         ir_sh_q <= {tdi_s, ir_sh_q[JDBS_IR_W-1:1]};
      end
   end

   // Unknown codes fall back to bypass so the chain length stays defined
   logic sel_id;
   assign sel_id = (ir_q == JDBS_IR_IDCODE);
   logic byp_q;
   logic [31:0] id_sh_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         byp_q <= 1'b0;
         id_sh_q <= 32'h0000_0000;
      end else if (tck_rise && tap_q == TAP_CAP_DR) begin
         byp_q <= 1'b0;
         id_sh_q <= IDCODE;
      end else if (tck_rise && tap_q == TAP_SH_DR) begin
         byp_q <= tdi_s;
         if (sel_id) begin
            id_sh_q <= {tdi_s, id_sh_q[31:1]};
         end
      end
   end

   logic tdo_q;
   logic tdo_oe_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (!dbg_on) begin
         tdo_q <= 1'b0;
         tdo_oe_q <= 1'b0;
      end else if (tck_fall) begin
         tdo_oe_q <= (tap_q == TAP_SH_DR) || (tap_q == TAP_SH_IR);
         if (tap_q == TAP_SH_IR) begin
            tdo_q <= ir_sh_q[0];
         end else begin
            tdo_q <= sel_id ? id_sh_q[0] : byp_q;
         end
      end
   end
   assign TDO = tdo_q;
   assign TDO_OE = tdo_oe_q;

   // AHB-Lite slave, zero wait states, always OKAY
   logic wr_pend_q;
   logic [11:0] wr_addr_q;
   logic [31:0] rdata_q;
   logic addr_ph;
   assign addr_ph = HSEL && HTRANS[1] && HREADY;
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = rdata_q;

   logic en_q;
   logic [15:0] count_q;
   logic [15:0] break_instruction_address_q;
   logic [7:0] setup_q [NUM_BP];
   logic [JDBS_ADDR_W-1:0] bp_addr_q [NUM_BP];
   logic [JDBS_DATA_W-1:0] bp_data_q [NUM_BP];

   // Tells whether an offset hits the given sub-register of breakpoint slot n
   function automatic logic bp_dec(input logic [11:0] a, input int n, input logic [1:0] sub);
      bp_dec = (a[11:4] == JDBS_OFS_BP_BASE[11:4] + 8'(n)) && (a[3:2] == sub);
   endfunction : bp_dec

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (HADDR[11:0] == JDBS_OFS_CTRL) begin
         rd_mux[JDBS_CTRL_EN_BIT] = en_q;
      end else if (HADDR[11:0] == JDBS_OFS_COUNT) begin
         rd_mux[15:0] = count_q;
      end else if (HADDR[11:0] == JDBS_OFS_BREAK_INSTRUCTION_ADDRESS) begin
         rd_mux[15:0] = break_instruction_address_q;
      end
      for (int n = 0; n < NUM_BP; n++) begin
         if (bp_dec(HADDR[11:0], n, JDBS_SUB_SETUP)) rd_mux = {24'h0, setup_q[n]};
         if (bp_dec(HADDR[11:0], n, JDBS_SUB_ADDR)) rd_mux = 32'(bp_addr_q[n]);
         if (bp_dec(HADDR[11:0], n, JDBS_SUB_DATA)) rd_mux = bp_data_q[n];
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         rdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_ph && HWRITE;
         if (addr_ph) begin
            wr_addr_q <= HADDR[11:0];
         end
         if (addr_ph && !HWRITE) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Snooper match logic
   logic [NUM_BP-1:0] hit;
   logic event_hit;
   logic fire;
   genvar g;
   generate
      for (g = 0; g < NUM_BP; g++) begin : g_bp
         jdbs_bus_t b;
         logic [1:0] acc;
         logic [2:0] cond;
         logic acc_ok;
         logic data_ok;
         assign acc = setup_q[g][JDBS_ACC_LSB +: 2];
         assign cond = setup_q[g][JDBS_COND_LSB +: 3];
         always_comb begin
            case (setup_q[g][JDBS_BUS_LSB +: 2])
               JDBS_BUS_X: b = X_BUS;
               JDBS_BUS_Y: b = Y_BUS;
               default: b = I_BUS;
            endcase
         end
         assign acc_ok = ((acc == JDBS_ACC_RD || acc == JDBS_ACC_RW) && b.rd) ||
                         ((acc == JDBS_ACC_WR || acc == JDBS_ACC_RW) && b.wr);
         always_comb begin
            case (cond)
               JDBS_COND_ANY: data_ok = 1'b1;
               JDBS_COND_EQ: data_ok = (b.data == bp_data_q[g]);
               JDBS_COND_NE: data_ok = (b.data != bp_data_q[g]);
               JDBS_COND_LT: data_ok = ($signed(b.data) < $signed(bp_data_q[g]));
               JDBS_COND_GE: data_ok = ($signed(b.data) >= $signed(bp_data_q[g]));
               default: data_ok = 1'b0;
            endcase
         end
         assign hit[g] = en_q && acc_ok && data_ok && (b.addr == bp_addr_q[g]);
      end
   endgenerate
   assign event_hit = |hit;
   assign fire = event_hit && (count_q == 16'h0000);

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         en_q <= 1'b0;
      end else if (fire) begin
         en_q <= 1'b0;
      end else if (wr_pend_q && wr_addr_q == JDBS_OFS_CTRL) begin
         en_q <= HWDATA[JDBS_CTRL_EN_BIT];
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         count_q <= JDBS_COUNT_RST;
      end else if (wr_pend_q && wr_addr_q == JDBS_OFS_COUNT) begin
         count_q <= HWDATA[15:0];
      end else if (event_hit && !fire) begin
         count_q <= count_q - 16'h0001;
      end
   end

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         break_instruction_address_q <= 16'h0000;
         BREAK_REQ <= 1'b0;
      end else begin
         BREAK_REQ <= fire;
         if (fire) begin
            break_instruction_address_q <= INSTR_ADDR;
         end
      end
   end

   // Breakpoint registers; hardware setting the triggered flag wins over a clear
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         for (int n = 0; n < NUM_BP; n++) begin
            setup_q[n] <= JDBS_SETUP_RST;
            bp_addr_q[n] <= '0;
            bp_data_q[n] <= '0;
         end
      end else begin
         for (int n = 0; n < NUM_BP; n++) begin
            if (wr_pend_q && bp_dec(wr_addr_q, n, JDBS_SUB_SETUP)) begin
               setup_q[n] <= HWDATA[7:0];
            end
            if (fire && hit[n]) begin
               setup_q[n][JDBS_TRIG_BIT] <= 1'b1;
            end
            if (wr_pend_q && bp_dec(wr_addr_q, n, JDBS_SUB_ADDR)) begin
               bp_addr_q[n] <= HWDATA[JDBS_ADDR_W-1:0];
            end
            if (wr_pend_q && bp_dec(wr_addr_q, n, JDBS_SUB_DATA)) begin
               bp_data_q[n] <= HWDATA;
            end
         end
      end
   end

   // Checks
   localparam logic [2:0] tms_hi_max = 3'(JDBS_TMS_RESET_CNT);
   logic [2:0] tms_hi_cnt_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         tms_hi_cnt_q <= 3'h0;
      end else if (tck_rise) begin
         tms_hi_cnt_q <= !tms_s ? 3'h0 : (tms_hi_cnt_q == tms_hi_max ? tms_hi_max : tms_hi_cnt_q + 3'h1);
      end
   end

   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);

   a_tms_reset_seq: assert property (tms_hi_cnt_q == tms_hi_max |-> tap_q == TAP_RESET)
      else $error("five TMS highs did not reach reset");
   a_dbg_off_hold: assert property (!dbg_on |=> tap_q == TAP_RESET && !TDO_OE)
      else $error("TAP active without debug mode");
   a_ir_update_load: assert property (tap_q == TAP_UPD_IR |=> ir_q == $past(ir_sh_q))
      else $error("instruction not loaded in update");
   a_bypass_delay: assert property (tck_rise && tap_q == TAP_SH_DR && !sel_id
      |=> byp_q == $past(tdi_s))
      else $error("bypass stage missed data");
   a_id_capture: assert property (tck_rise && tap_q == TAP_CAP_DR |=> id_sh_q == IDCODE)
      else $error("identification not captured");
   a_halt_on_fire: assert property (fire |=> !en_q && BREAK_REQ && hit == '0)
      else $error("snooper kept running after break");
   a_count_dec: assert property (event_hit && count_q != 16'h0000 && !wr_pend_q
      |=> count_q == $past(count_q) - 16'h0001)
      else $error("countdown did not decrement");
   a_fire_cause: assert property (BREAK_REQ |-> $past(event_hit) &&
      $past(count_q) == 16'h0000)
      else $error("break without zero countdown");
   a_break_pulse: assert property (BREAK_REQ |=> !BREAK_REQ)
      else $error("break request longer than one cycle");
   a_break_instruction_address_capture: assert property (fire |=> break_instruction_address_q == $past(INSTR_ADDR))
      else $error("instruction address not captured");
   a_trig_flag_set: assert property (fire && hit[0] |=> setup_q[0][JDBS_TRIG_BIT])
      else $error("triggered flag not set");
   a_disabled_no_hit: assert property (setup_q[0][JDBS_COND_LSB +: 3] == 3'h0 ||
      setup_q[0][JDBS_ACC_LSB +: 2] == 2'h0 |-> !hit[0])
      else $error("disabled breakpoint matched");
endmodule : jdbs_top

//--- dv/jdbs_probe.sv
`timescale 1ns/1ps
module jdbs_probe (
   input wire logic clk,
   input wire logic tdo,
   input wire logic tdo_oe,
   output logic tck,
   output logic tms,
   output logic tdi
);
   // Test clock rests high and stands still between frames
   initial begin
      tck = 1'b1;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // One test clock of eight system clocks; TDO taken just before the rise
   task automatic clk_bit(input logic m, input logic d, output logic q, inout logic oe);
      tck <= 1'b0;
      tms <= m;
      tdi <= d;
      repeat (4) @(posedge clk) oe = oe | tdo_oe;
      q = tdo;
      tck <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : clk_bit

   // Starts and ends in Run-Test/Idle; last bit leaves the shift state
   task automatic scan(input logic ir, input int n, input logic [31:0] din,
      output logic [31:0] dout, output logic oe);
      logic q;
      oe = 1'b0;
      dout = 32'h0;
      clk_bit(1'b1, 1'b0, q, oe);
      if (ir) clk_bit(1'b1, 1'b1, q, oe);
      clk_bit(1'b0, 1'b0, q, oe);
      clk_bit(1'b0, 1'b1, q, oe);
      for (int i = 0; i < n; i++) begin
         clk_bit(i == n - 1, din[i], q, oe);
         dout[i] = q;
      end
      clk_bit(1'b1, 1'b0, q, oe);
      clk_bit(1'b0, 1'b1, q, oe);
   endtask : scan

   task automatic tap_reset();
      logic q;
      logic oe;
      oe = 1'b0;
      repeat (5) clk_bit(1'b1, 1'b0, q, oe);
      clk_bit(1'b0, 1'b0, q, oe);
   endtask : tap_reset
endmodule : jdbs_probe

//--- dv/tb.sv
`timescale 1ns/1ps
module tb import jdbs_pkg::*;;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic dbg = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [15:0] iaddr = 16'h0;
   jdbs_bus_t bus [3] = '{default: '0};
   wire logic [31:0] hrdata;
   wire logic hready;
   wire logic hresp;
   wire logic tck;
   wire logic tms;
   wire logic tdi;
   wire logic tdo;
   wire logic tdo_oe;
   wire logic breq;
   int fails = 0;
   int samples_checked = 0;

   always #12.5 clock = ~clock;

   jdbs_top dut (.CLOCK(clock), .ARST_N(arst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
      .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .DBG_MODE(dbg), .TCK(tck),
      .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe), .BREAK_REQ(breq),
      .I_BUS(bus[0]), .X_BUS(bus[1]), .Y_BUS(bus[2]), .INSTR_ADDR(iaddr));

   jdbs_probe probe (.clk(clock), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
      .tdi(tdi));

   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_rdy();
      do begin
         @(posedge clock);
      end while (hready !== 1'b1);
   endtask : wait_rdy

   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      chk({31'h0, hresp}, 32'h0);
   endtask : ahb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      ahb(1'b1, a, d, q);
   endtask : wr

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      ahb(1'b0, a, 32'h0, q);
      chk(q, exp);
   endtask : rdchk

   function automatic logic cond_ok(input logic [2:0] c, input logic [31:0] d);
      case (c)
         3'h1: return 1'b1;
         3'h2: return d == 32'h10;
         3'h3: return d != 32'h10;
         3'h4: return $signed(d) < $signed(32'h10);
         3'h5: return $signed(d) >= $signed(32'h10);
         default: return 1'b0;
      endcase
   endfunction : cond_ok

   task automatic t_regs();
      rdchk(12'h000, 32'h0);
      rdchk(12'h004, 32'h0);
      rdchk(12'h008, 32'h0);
      rdchk(12'h0B0, 32'h0);
      wr(12'h004, 32'h1234_5678);
      rdchk(12'h004, 32'h5678);
      wr(12'h008, 32'hFFFF);
      rdchk(12'h008, 32'h0);
      wr(12'h0B4, 32'hFFFF_FFFF);
      rdchk(12'h0B4, 32'hFFFF);
      wr(12'h0B8, 32'h89AB_CDEF);
      rdchk(12'h0B8, 32'h89AB_CDEF);
      wr(12'h0B0, 32'h1AB);
      rdchk(12'h0B0, 32'hAB);
      wr(12'h0B0, 32'h0);
      wr(12'h030, 32'h1);
      rdchk(12'h030, 32'h0);
      $display("register test done");
   endtask : t_regs

   task automatic t_jtag();
      logic [31:0] q;
      logic oe;
      probe.tap_reset();
      probe.scan(1'b0, 32, 32'h0, q, oe);
      chk(q, JDBS_IDCODE_DEF);
      chk({31'h0, oe}, 32'h1);
      probe.scan(1'b1, 4, 32'h0, q, oe);
      chk(q, {28'h0, JDBS_IR_CAPTURE});
      probe.scan(1'b0, 8, 32'hA5, q, oe);
      chk(q, 32'h4A);
      probe.scan(1'b1, 4, 32'hF, q, oe);
      chk(q, {28'h0, JDBS_IR_CAPTURE});
      probe.scan(1'b0, 32, 32'h0, q, oe);
      chk(q, JDBS_IDCODE_DEF);
      probe.scan(1'b1, 4, 32'h5, q, oe);
      chk(q, {28'h0, JDBS_IR_CAPTURE});
      probe.scan(1'b0, 8, 32'h3C, q, oe);
      chk(q, 32'h78);
      probe.tap_reset();
      probe.scan(1'b0, 32, 32'h0, q, oe);
      chk(q, JDBS_IDCODE_DEF);
      dbg <= 1'b0;
      probe.scan(1'b0, 32, 32'h0, q, oe);
      chk(q, 32'h0);
      chk({31'h0, oe}, 32'h0);
      dbg <= 1'b1;
      $display("jtag test done");
   endtask : t_jtag

   // One match attempt on breakpoint 0 with the countdown at zero
   task automatic run_bp(input int b, input logic [1:0] a, input logic [2:0] c,
      input int j, input logic w, input logic [31:0] d, input logic e);
      logic hit;
      hit = 1'b0;
      wr(12'h040, {25'h0, b[1:0], a, c});
      wr(12'h044, 32'h0100);
      wr(12'h048, 32'h10);
      wr(12'h004, 32'h0);
      wr(12'h000, 32'h1);
      bus[j] <= '{rd: ~w, wr: w, addr: 16'h0100, data: d};
      iaddr <= 16'hC0DE ^ d[15:0];
      @(posedge clock);
      bus[j] <= '0;
      iaddr <= 16'h0;
      repeat (4) @(posedge clock) hit = hit | breq;
      chk({31'h0, hit}, {31'h0, e});
      if (e) begin
         rdchk(12'h008, {16'h0, 16'hC0DE ^ d[15:0]});
         rdchk(12'h040, {24'h0, 1'b1, b[1:0], a, c});
         rdchk(12'h000, 32'h0);
      end
      wr(12'h000, 32'h0);
   endtask : run_bp

   task automatic t_access();
      for (int b = 0; b < 3; b++)
         for (int a = 0; a < 4; a++)
            for (int w = 0; w < 2; w++)
               for (int j = 0; j < 3; j++)
                  run_bp(b, a[1:0], JDBS_COND_ANY, j, w[0], 32'h10,
                     (j == b) && (w[0] ? a[1] : a[0]));
      $display("access test done");
   endtask : t_access

   task automatic t_cond();
      logic [31:0] vals [3];
      vals = '{32'h10, 32'hFFFF_FFF0, 32'h20};
      for (int c = 0; c < 6; c++)
         for (int k = 0; k < 3; k++)
            run_bp(1, JDBS_ACC_RD, c[2:0], 1, 1'b0, vals[k],
               cond_ok(c[2:0], vals[k]));
      $display("condition test done");
   endtask : t_cond

   // Back-to-back matches: two counted, the third breaks, the fourth is ignored
   task automatic t_count();
      int n;
      int at;
      n = 0;
      at = 0;
      wr(12'h040, 32'h5900);
      wr(12'h040, 32'h59);
      wr(12'h044, 32'h0300);
      wr(12'h0B0, 32'h59);
      wr(12'h0B4, 32'h0200);
      wr(12'h004, 32'h2);
      wr(12'h000, 32'h1);
      bus[2] <= '{rd: 1'b0, wr: 1'b1, addr: 16'h0200, data: 32'h0};
      iaddr <= 16'h1000;
      for (int i = 1; i <= 8; i++) begin
         @(posedge clock);
         iaddr <= 16'h1000 + i[15:0];
         if (i == 4) bus[2] <= '0;
         if (breq === 1'b1) begin
            n++;
            at = i;
         end
      end
      chk(n, 1);
      chk(at, 4);
      rdchk(12'h004, 32'h0);
      rdchk(12'h000, 32'h0);
      rdchk(12'h008, 32'h1002);
      rdchk(12'h0B0, 32'hD9);
      rdchk(12'h040, 32'h59);
      $display("countdown test done");
   endtask : t_count

   initial begin
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      @(posedge clock);
      t_regs();
      t_jtag();
      t_access();
      t_cond();
      t_count();
      complete_run();
   end

   initial begin
      #1_000_000;
      fails++;
      complete_run();
   end
endmodule : tb
